// file: inc/epic_regs.vh
// Register map, field positions and reset values of the external pin
// interrupt controller; included by the top design file of the block only.
// How it works
// - Selected edge sets flag bit 15 always
// - Flag reads, clears by write or reset
// - Each enabled edge raises one request, up to three pending
// - Clearing flag cancels pending pin requests
// - Bit 6 returns live pin level
// - Bit 2 picks falling or rising edge
// - Bit 1 picks high or low priority
// - Bit 0 enables the maskable request
// - Nonmaskable selection overrides priority and enable
// - Bit 4 sets pin direction, lines b/c; bit 0 set forces input
// - Bit 3 sets driven level, lines b/c
// - Reserved bits ignore writes, read zero
`ifndef EPIC_REGS_VH
`define EPIC_REGS_VH

// Register indexes; byte address is four times the index
`define EPIC_IDX_A    16'h7070
`define EPIC_IDX_NMI  16'h7072
`define EPIC_IDX_B    16'h7078
`define EPIC_IDX_C    16'h707A
`define EPIC_IDX_STS  16'h7080
`define EPIC_IDX_MSK  16'h7082
`define EPIC_IDX_CFG  16'h7084

// Control register field positions
`define EPIC_B_FLAG   15
`define EPIC_B_PIN    6
`define EPIC_B_DIR    4
`define EPIC_B_DOUT   3
`define EPIC_B_POL    2
`define EPIC_B_PRI    1
`define EPIC_B_EN     0

// Config register fields: nonmaskable routing per line
`define EPIC_B_CFG_NMI 0
`define EPIC_B_CFG_A   1

// Reset values
`define EPIC_CTL_RST  1'b0
`define EPIC_CFG_RST  2'h1
`define EPIC_STS_RST  4'h0
`define EPIC_MSK_RST  4'h0

`endif

// file: src/epic_pin_chan.v
// One interrupt pin: synchroniser, edge detector, sticky flag and
// pending request counter.
// Assumes pinRaw is asynchronous; all other inputs on core_clk.
`timescale 1ns/1ps
module epic_pin_chan (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       pinRaw,
  input  wire       polRise,
  input  wire       reqEnable,
  input  wire       flagClr,
  input  wire       reqAck,
  output wire       pinLevel,
  output wire       edgePulse,
  output wire       flagOut,
  output wire       pendOut
);

  // ==========================================================
  // Synchroniser and edge detection
  reg        sync1_q;   // First stage, read only by sync2
  reg        sync2_q;   // Second stage, safe level
  reg        prev_q;    // Previous safe sample
  reg  [2:0] primed_q;  // Sample ages; top bit set once prev is real
  reg        flag_q;    // Sticky edge flag
  reg  [1:0] pend_q;    // Outstanding request count
  reg  [1:0] pend_d;
  wire       riseSeen;
  wire       fallSeen;
  wire       reqEdge;

  // Sample chain; no edge until prev holds a synchronised pin sample,
  // so a pin idling high gives no false edge after reset
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      prev_q   <= 1'b0;
      primed_q <= 3'h0;
    end else begin
      sync1_q  <= pinRaw;
      sync2_q  <= sync1_q;
      prev_q   <= sync2_q;
      primed_q <= {primed_q[1:0], 1'b1};
    end
  end

  assign riseSeen  = primed_q[2] & sync2_q & ~prev_q;
  assign fallSeen  = primed_q[2] & ~sync2_q & prev_q;
  assign edgePulse = polRise ? riseSeen : fallSeen;
  assign reqEdge   = edgePulse & reqEnable;
  assign pinLevel  = sync2_q;

  // ==========================================================
  // Flag: set wins over a clear in the same cycle
  always @(posedge core_clk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (edgePulse) begin
      flag_q <= 1'b1;
    end else if (flagClr) begin
      flag_q <= 1'b0;
    end
  end

  // Pending count: one request per edge, saturating at three, even with flag set
  always @* begin
    pend_d = pend_q;
    if (flagClr) begin
      pend_d = 2'h0;
    end else if (reqAck && pend_q != 2'h0) begin
      pend_d = pend_q - 2'h1;
    end
    if (reqEdge && pend_d != 2'h3) begin
      pend_d = pend_d + 2'h1;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      pend_q <= 2'h0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign flagOut = flag_q;
  assign pendOut = (pend_q != 2'h0);

endmodule // epic_pin_chan

// file: src/epic_ctrl.v
// Top of the external pin interrupt controller: APB register file,
// four pin channels, digital I/O for lines b and c, summary IRQ.
// Assumes APB master on core_clk; pins are asynchronous inputs.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "epic_regs.vh"
module epic_ctrl (
  input  wire        core_clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [17:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Pins: 0 nonmaskable, 1 line a, 2 line b, 3 line c
  input  wire [3:0]  pinIn,
  output reg  [1:0]  gpioOut,
  output reg  [1:0]  gpioOe_n,
  // Requests towards CPU interrupt logic
  input  wire [3:0]  reqAck,
  output wire [3:0]  reqPend,
  output reg  [3:0]  reqLowPri,
  output reg  [3:0]  reqNonMask,
  // Summary interrupt
  output wire        irqOut
);

  // ==========================================================
  // Address decode
  wire [17:0] addrA;    // Byte address, line a control
  wire [17:0] addrNmi;  // Byte address, nonmaskable line
  wire [17:0] addrB;    // Byte address, line b control
  wire [17:0] addrC;    // Byte address, line c control
  wire [17:0] addrSts;  // Byte address, event status
  wire [17:0] addrMsk;  // Byte address, event mask
  wire [17:0] addrCfg;  // Byte address, routing config
  wire [3:0]  hitCtl;   // One-hot control hit, pin order
  wire        hitSts;
  wire        hitMsk;
  wire        hitCfg;
  wire        hitAny;
  wire        setupPh;  // APB setup cycle
  wire        accessPh; // APB access cycle
  wire        wrAcc;    // Write takes effect
  wire        wrLo;     // Low byte lane written
  wire        wrHi;     // High byte lane written

  assign addrA   = {`EPIC_IDX_A,   2'b00};
  assign addrNmi = {`EPIC_IDX_NMI, 2'b00};
  assign addrB   = {`EPIC_IDX_B,   2'b00};
  assign addrC   = {`EPIC_IDX_C,   2'b00};
  assign addrSts = {`EPIC_IDX_STS, 2'b00};
  assign addrMsk = {`EPIC_IDX_MSK, 2'b00};
  assign addrCfg = {`EPIC_IDX_CFG, 2'b00};

  // Channel order matches pin order
  assign hitCtl[0] = (paddr == addrNmi);
  assign hitCtl[1] = (paddr == addrA);
  assign hitCtl[2] = (paddr == addrB);
  assign hitCtl[3] = (paddr == addrC);
  assign hitSts    = (paddr == addrSts);
  assign hitMsk    = (paddr == addrMsk);
  assign hitCfg    = (paddr == addrCfg);
  assign hitAny    = (|hitCtl) | hitSts | hitMsk | hitCfg;

  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign wrAcc    = accessPh & pwrite & hitAny;
  assign wrLo     = wrAcc & pstrb[0];
  assign wrHi     = wrAcc & pstrb[1];

  // Zero wait states; read data is staged in the setup cycle
  assign pready  = 1'b1;
  // Unmapped addresses answer with an error
  assign pslverr = accessPh & ~hitAny;

  // ==========================================================
  // Control registers
  reg  [3:0] polQ;      // Edge select per pin
  reg  [3:0] priQ;      // Priority select per pin
  reg  [3:0] enQ;       // Maskable enable per pin
  reg  [1:0] dirQ;      // Direction, lines b and c
  reg  [1:0] doutQ;     // Output level, lines b and c
  reg  [1:0] cfg_q;     // Nonmaskable routing
  reg  [3:0] msk_q;     // Summary interrupt mask
  reg  [3:0] sts_q;     // Sticky event status
  reg  [3:0] sts_d;
  reg  [3:0] rdSnap_q;  // Status bits returned by a read
  wire [3:0] flagClr;   // Per-pin flag clear strobe
  wire [3:0] nmSel;     // Nonmaskable selection per pin
  wire [3:0] reqEnable;
  wire [3:0] pinLevel;
  wire [3:0] edgePulse;
  wire [3:0] flag;

  // Writing one to the flag bit clears it
  assign flagClr = hitCtl & {4{wrHi & pwdata[`EPIC_B_FLAG]}};

  // Only the nonmaskable line and line a can be routed nonmaskable
  assign nmSel = {2'b00, cfg_q[`EPIC_B_CFG_A], cfg_q[`EPIC_B_CFG_NMI]};

  // Nonmaskable routing ignores the enable bit
  assign reqEnable = nmSel | enQ;

  // Low byte fields; reserved bits are never stored
  always @(posedge core_clk) begin
    if (!rst_n) begin
      polQ  <= {4{`EPIC_CTL_RST}};
      priQ  <= {4{`EPIC_CTL_RST}};
      enQ   <= {4{`EPIC_CTL_RST}};
      dirQ  <= {2{`EPIC_CTL_RST}};
      doutQ <= {2{`EPIC_CTL_RST}};
    end else if (wrLo) begin
      // Only addressed pin takes the write
      polQ <= (polQ & ~hitCtl) | (hitCtl & {4{pwdata[`EPIC_B_POL]}});
      priQ <= (priQ & ~hitCtl) | (hitCtl & {4{pwdata[`EPIC_B_PRI]}});
      enQ  <= (enQ & ~hitCtl) | (hitCtl & {4{pwdata[`EPIC_B_EN]}});
      // Direction and level exist for lines b and c only
      dirQ  <= (dirQ & ~hitCtl[3:2])
             | (hitCtl[3:2] & {2{pwdata[`EPIC_B_DIR]}});
      doutQ <= (doutQ & ~hitCtl[3:2])
             | (hitCtl[3:2] & {2{pwdata[`EPIC_B_DOUT]}});
    end
  end

  // Config and mask registers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_q <= `EPIC_CFG_RST;
      msk_q <= `EPIC_MSK_RST;
    end else if (wrLo) begin
      if (hitCfg) begin
        cfg_q <= pwdata[1:0];
      end
      if (hitMsk) begin
        msk_q <= pwdata[3:0];
      end
    end
  end

  // ==========================================================
  // Pin channels
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gChan
      epic_pin_chan uChan (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pinRaw    (pinIn[gi]),
        .polRise   (polQ[gi]),
        .reqEnable (reqEnable[gi]),
        .flagClr   (flagClr[gi]),
        .reqAck    (reqAck[gi]),
        .pinLevel  (pinLevel[gi]),
        .edgePulse (edgePulse[gi]),
        .flagOut   (flag[gi]),
        .pendOut   (reqPend[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Request attributes towards the CPU
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reqLowPri  <= 4'h0;
      reqNonMask <= 4'h0;
    end else begin
      // Priority is meaningless on a nonmaskable route
      reqLowPri  <= priQ & ~nmSel;
      reqNonMask <= nmSel;
    end
  end

  // ==========================================================
  // Digital I/O on lines b and c
  always @(posedge core_clk) begin
    if (!rst_n) begin
      gpioOut  <= 2'h0;
      gpioOe_n <= 2'h3;
    end else begin
      gpioOut  <= doutQ;
      // Drive only with interrupts off and direction output
      gpioOe_n <= ~(dirQ & ~enQ[3:2]);
    end
  end

  // ==========================================================
  // Sticky event status, cleared by reading it
  always @* begin
    sts_d = sts_q;
    if (accessPh && !pwrite && hitSts) begin
      sts_d = sts_q & ~rdSnap_q;
    end
    // New events win over the read clear
    sts_d = sts_d | edgePulse;
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      sts_q <= `EPIC_STS_RST;
    end else begin
      sts_q <= sts_d;
    end
  end

  assign irqOut = |(sts_q & msk_q);

  // ==========================================================
  // Read data, staged during the setup cycle
  reg  [15:0] ctlWord [0:3];
  integer     ri;

  // Control words; reserved bits read as zero
  always @* begin
    for (ri = 0; ri < 4; ri = ri + 1) begin
      ctlWord[ri] = 16'h0000;
      ctlWord[ri][`EPIC_B_FLAG] = flag[ri];
      ctlWord[ri][`EPIC_B_PIN]  = pinLevel[ri];
      ctlWord[ri][`EPIC_B_POL]  = polQ[ri];
      ctlWord[ri][`EPIC_B_PRI]  = priQ[ri];
      ctlWord[ri][`EPIC_B_EN]   = enQ[ri];
    end
    ctlWord[2][`EPIC_B_DIR]  = dirQ[0];
    ctlWord[2][`EPIC_B_DOUT] = doutQ[0];
    ctlWord[3][`EPIC_B_DIR]  = dirQ[1];
    ctlWord[3][`EPIC_B_DOUT] = doutQ[1];
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      prdata   <= 32'h00000000;
      rdSnap_q <= 4'h0;
    end else if (setupPh && !pwrite) begin
      rdSnap_q <= hitSts ? sts_q : 4'h0;
      if (hitCtl[0]) begin
        prdata <= {16'h0000, ctlWord[0]};
      end else if (hitCtl[1]) begin
        prdata <= {16'h0000, ctlWord[1]};
      end else if (hitCtl[2]) begin
        prdata <= {16'h0000, ctlWord[2]};
      end else if (hitCtl[3]) begin
        prdata <= {16'h0000, ctlWord[3]};
      end else if (hitSts) begin
        prdata <= {28'h0000000, sts_q};
      end else if (hitMsk) begin
        prdata <= {28'h0000000, msk_q};
      end else if (hitCfg) begin
        prdata <= {30'h0000000, cfg_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // epic_ctrl

// file: bench/epic_ctrl_checker.sv
// Port-level assertions for the pin interrupt controller.
// Assumes one core_clk domain with a synchronous active-low reset.
`timescale 1ns/1ps
module epic_ctrl_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [3:0]  pinIn,
  input wire logic [1:0]  gpioOut,
  input wire logic [1:0]  gpioOe_n,
  input wire logic [3:0]  reqAck,
  input wire logic [3:0]  reqPend,
  input wire logic [3:0]  reqLowPri,
  input wire logic [3:0]  reqNonMask,
  input wire logic        irqOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ====================
  // Helpers
  logic [3:0] pinPrev_q; // Last pin sample
  logic [3:0] since_q;   // Cycles since a pin moved
  wire        wrAcc = psel && penable && pwrite;
  // Age of the latest pin movement, saturating
  always @(posedge core_clk) begin
    pinPrev_q <= pinIn;
    if (!rst_n) since_q <= 4'hF;
    else if (pinIn != pinPrev_q) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  // ====================
  // Assertions
  rst_values_a: assert property (disable iff (1'b0) !rst_n |=>
    reqPend == 4'h0 && gpioOe_n == 2'h3 && !irqOut) else $error("reset values wrong");
  err_scope_a: assert property (pslverr |-> psel && penable)
    else $error("error outside unmapped access");
  // Read data is only staged by reads; a write leaves it standing
  err_rdata_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  pend_cause_a: assert property (|(reqPend & ~$past(reqPend)) |->
    since_q inside {[4'h1:4'h6]}) else $error("request without pin edge");
  irq_cause_a: assert property ($rose(irqOut) |-> since_q <= 4'h6 || $past(wrAcc))
    else $error("interrupt without cause");
  pend_drop_a: assert property (|(~reqPend & $past(reqPend)) |->
    $past(|reqAck || wrAcc)) else $error("request vanished");
  lowpri_route_a: assert property ((reqLowPri & reqNonMask) == 4'h0)
    else $error("priority on nonmaskable line");
  // Pin outputs sit one flop behind the register, two cycles after the write
  dir_write_a: assert property ($changed(gpioOe_n) |-> $past(wrAcc, 2))
    else $error("direction moved without write");
  out_write_a: assert property ($changed(gpioOut) |-> $past(wrAcc, 2))
    else $error("output moved without write");
endmodule // epic_ctrl_checker

// file: bench/epic_cpu_model.sv
// CPU-side model: acknowledges pending pin requests one at a time.
// Assumes level requests on core_clk; acks are one-cycle pulses.
`timescale 1ns/1ps
module epic_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ackOn,
  input  wire logic [3:0] ackWait,
  input  wire logic [3:0] reqPend,
  output logic      [3:0] reqAck,
  output logic      [7:0] ackCount
);
  logic [3:0] wait_q; // Idle cycles before next ack
  // Lowest pending pin first, ackWait plus two gap cycles after each pulse
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reqAck <= 4'h0;
      wait_q <= 4'h0;
      ackCount <= 8'h00;
    end else if (reqAck != 4'h0) begin
      reqAck <= 4'h0;
    end else if (ackOn && reqPend != 4'h0 && wait_q > ackWait) begin
      reqAck <= reqPend & (~reqPend + 4'h1);
      wait_q <= 4'h0;
      ackCount <= ackCount + 8'h01;
    end else if (ackOn && reqPend != 4'h0) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // epic_cpu_model

// file: bench/epic_ctrl_bench.sv
// Self-checking bench of the pin interrupt controller.
// Assumes design, checker and CPU model are compiled before it.
`timescale 1ns/1ps
module epic_ctrl_bench;
  // ====================
  // Signals
  logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, irqOut, err, ackOn = 0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF, reqAck, reqPend, reqLowPri, reqNonMask, extPin = 4'h0;
  logic [3:0]  ackWait = 4'h0;
  logic [1:0]  gpioOut, gpioOe_n;
  logic [7:0]  ackCount, base;
  wire  [3:0]  pinIn = {gpioOe_n[1] ? extPin[3] : gpioOut[1],
                        gpioOe_n[0] ? extPin[2] : gpioOut[0], extPin[1:0]};
  int          n_errors = 0, checks_done = 0;
  localparam logic [17:0] A_CTL = 18'h1C1C0, N_CTL = 18'h1C1C8, B_CTL = 18'h1C1E0;
  localparam logic [17:0] C_CTL = 18'h1C1E8, STS = 18'h1C200, MSK = 18'h1C208;
  localparam logic [17:0] CFG = 18'h1C210;
  always #50 core_clk = ~core_clk;
  epic_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pinIn(pinIn), .gpioOut(gpioOut),
    .gpioOe_n(gpioOe_n), .reqAck(reqAck), .reqPend(reqPend), .reqLowPri(reqLowPri),
    .reqNonMask(reqNonMask), .irqOut(irqOut));
  epic_cpu_model u_cpu (.core_clk(core_clk), .rst_n(rst_n), .ackOn(ackOn),
    .ackWait(ackWait), .reqPend(reqPend), .reqAck(reqAck), .ackCount(ackCount));
  // ====================
  // Shared tasks
  task automatic complete_run;
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge core_clk);
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(logic w, logic [17:0] a, logic [15:0] d);
    int k = 0;
    @(posedge core_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {16'h0, d}; penable <= 0;
    @(posedge core_clk);
    penable <= 1;
    do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    if (pready !== 1'b1) begin
      $display("FAIL pready expected 1 seen %b", pready);
      n_errors++;
      complete_run;
    end
  endtask
  task automatic rdchk(string nm, logic [17:0] a, logic [15:0] e);
    apb(0, a, 16'h0);
    chk(nm, e, rd[15:0]);
  endtask
  task automatic pin(int i, logic v);
    @(posedge core_clk);
    extPin[i] <= v;
    cyc(5);
  endtask
  // Let the CPU model consume a pin's requests
  task automatic drain(int i);
    int k = 0;
    ackOn <= 1;
    while (reqPend[i] !== 1'b0 && k < 200) begin @(posedge core_clk); k++; end
    chk("drain", 0, reqPend[i]);
    ackOn <= 0;
    if (k >= 200) complete_run;
  endtask
  // ====================
  // Scenarios
  // Reset values, reserved bits, byte lanes, unmapped access
  task automatic scn_regs;
    rdchk("a reset", A_CTL, 16'h0000);
    apb(1, A_CTL, 16'h7FB8);
    rdchk("a reserved", A_CTL, 16'h0000);
    apb(1, 18'h1C1C4, 16'h0007);
    chk("unmapped", 1, err);
    apb(0, 18'h1C1C4, 16'h0);
    chk("unmapped rd err", 1, err);
    chk("unmapped rd data", 0, rd);
    pstrb <= 4'h2;
    apb(1, A_CTL, 16'h0005);
    pstrb <= 4'hF;
    rdchk("a lane", A_CTL, 16'h0000);
  endtask
  // Polled flag, counted requests, clear cancels pending
  task automatic scn_line_a;
    apb(1, A_CTL, 16'h0004);
    pin(1, 1);
    rdchk("a poll", A_CTL, 16'h8044);
    chk("a masked", 0, reqPend[1]);
    apb(1, A_CTL, 16'h0005);
    pin(1, 0); pin(1, 1); pin(1, 0); pin(1, 1);
    base = ackCount; ackWait <= 4'h3;
    drain(1);
    chk("a two acks", 8'h02, ackCount - base);
    pin(1, 0); pin(1, 1);
    apb(1, A_CTL, 16'h8005);
    cyc(1);
    chk("a cancel", 0, reqPend[1]);
    rdchk("a clear", A_CTL, 16'h0045);
  endtask
  // Line c falling edge selection
  task automatic scn_line_c;
    apb(1, C_CTL, 16'h0001);
    pin(3, 1);
    chk("c rise", 0, reqPend[3]);
    pin(3, 0);
    chk("c fall", 1, reqPend[3]);
    rdchk("c flag", C_CTL, 16'h8001);
    ackWait <= 4'h0;
    drain(3);
  endtask
  // Priority and nonmaskable routing
  task automatic scn_route;
    apb(1, A_CTL, 16'h0007);
    cyc(2);
    chk("a low", 1, reqLowPri[1]);
    apb(1, N_CTL, 16'h0003);
    apb(1, CFG, 16'h0003);
    cyc(2);
    chk("routing", 8'h30, {reqNonMask, reqLowPri});
    apb(1, A_CTL, 16'h0004);
    pin(1, 0); pin(1, 1);
    chk("nm ignores enable", 1, reqPend[1]);
    drain(1);
    apb(1, CFG, 16'h0001);
    apb(1, A_CTL, 16'h0005);
  endtask
  // Digital I/O on lines b and c
  task automatic scn_gpio;
    apb(1, B_CTL, 16'h0010);
    cyc(2);
    chk("b drive low", 0, {gpioOe_n[0], gpioOut[0]});
    apb(1, B_CTL, 16'h0018);
    cyc(4);
    rdchk("b high", B_CTL, 16'h0058);
    apb(1, B_CTL, 16'h0008);
    cyc(5);
    chk("b input", 1, gpioOe_n[0]);
    rdchk("b fall", B_CTL, 16'h8008);
    apb(1, C_CTL, 16'h0018);
    cyc(2);
    chk("c drive high", 1, {gpioOe_n[1], gpioOut[1]});
    apb(1, C_CTL, 16'h0019);
    cyc(2);
    chk("c enable input", 1, gpioOe_n[1]);
    cyc(3);
    chk("c enabled edge", 1, reqPend[3]);
    drain(3);
  endtask
  // Status read clear and summary interrupt
  task automatic scn_status;
    apb(1, MSK, 16'h0002);
    apb(0, STS, 16'h0);
    cyc(1);
    chk("irq idle", 0, irqOut);
    pin(1, 0); pin(1, 1);
    chk("irq set", 1, irqOut);
    rdchk("status", STS, 16'h0002);
    cyc(1);
    chk("irq read", 0, irqOut);
    drain(1);
  endtask
  // ====================
  // Main sequence
  initial begin
    cyc(16);
    rst_n <= 1;
    scn_regs;
    scn_line_a;
    scn_line_c;
    scn_route;
    scn_gpio;
    scn_status;
    complete_run;
  end
endmodule // epic_ctrl_bench
bind epic_ctrl epic_ctrl_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .pinIn(pinIn), .gpioOut(gpioOut),
  .gpioOe_n(gpioOe_n), .reqAck(reqAck), .reqPend(reqPend), .reqLowPri(reqLowPri),
  .reqNonMask(reqNonMask), .irqOut(irqOut));
